// File: verif/eer_core_model.sv
module eer_core_model
  import eer_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            memWrite,
  input  wire logic [31:0]     memAddr,
  input  wire logic [31:0]     memWdata,
  input  wire logic [FW_W-1:0] stackWordIdx,
  input  wire logic [31:0]     vecAddr,
  output      logic            memReady,
  output      logic            vecValid,
  output      logic [31:0]     vecData,
  output      logic [31:0]     stackWordData
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // Stack memory and vector table
  logic [31:0] mem [logic [31:0]];
  int          words = 0;
  // Word tied to its index, so a misplaced word shows
  assign stackWordData = {26'h2aaaaaa, stackWordIdx};
  // Scrambled while not valid, never the last value
  assign vecData = vecValid ? (vecAddr | 32'h1) : ~vecAddr;
  initial
  begin
    memReady = 1'b0;
    vecValid = 1'b0;
  end
  // Random stalls on both paths, so slow answers are covered too
  always @(posedge clk)
  begin
    memReady <= 1'($urandom);
    vecValid <= 1'($urandom);
    if (memWrite && memReady)
    begin
      mem[memAddr] = memWdata;
      words++;
    end
  end
endmodule : eer_core_model

// File: verif/exception_entry_return_control_tb.sv
module exception_entry_return_control_tb
  import eer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // Stimulus and observed signals
  localparam logic [31:0] VS = 32'h1000;
  localparam logic [31:0] VN = 32'h2000;
  logic clk = 0, resetn = 0, coreSecure = 0, spIsProcess = 0, fpActive = 0;
  logic fpSecureTreatmentFlag = 0, pcWrite = 0, regWrite = 0, regRead = 0;
  logic [15:0] irqPending = '0;
  logic [127:0] irqPrio = '0, p;
  logic [31:0] curSp = 32'h8000, returnAddr = 0, pcValue = 0, regWdata = 0, d;
  logic [7:0] regAddr = 0, gm;
  logic [1:0] pcWriteKind = 0;
  logic [2:0] split;
  logic memWrite, vecReq, handlerStart, linkRegWrite, clearRegs, tailChain;
  logic unstackStart, inHandlerMode, memReady, vecValid;
  logic [31:0] memAddr, memWdata, newSp, vecAddr, handlerPc, linkRegValue;
  logic [31:0] regRdata, vecData, stackWordData;
  logic [FW_W-1:0] stackWordIdx;
  int fail_count = 0, checks = 0, cyc = 0, it, a, b, w, l, f, s, w0, n;

  eer_exception_ctrl #(.N_IRQ(8), .HAS_FP(1'b1), .VBASE_S(VS), .VBASE_N(VN)) dut (
    .clk, .resetn, .irqPending, .irqPrio, .coreSecure, .spIsProcess, .curSp, .fpActive,
    .fpSecureTreatmentFlag, .returnAddr, .stackWordData, .memReady, .memWrite, .memAddr,
    .memWdata, .stackWordIdx, .newSp, .vecReq, .vecAddr, .vecValid, .vecData, .pcWrite,
    .pcWriteKind, .pcValue, .handlerStart, .handlerPc, .linkRegWrite, .linkRegValue,
    .clearRegs, .tailChain, .unstackStart, .inHandlerMode, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata);
  eer_core_model core (.clk, .memWrite, .memAddr, .memWdata, .stackWordIdx, .vecAddr,
    .memReady, .vecValid, .vecData, .stackWordData);

  // ====
  // Clock and hang guard
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end

  // ====
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] dv);
    regAddr <= ad;
    regWdata <= dv;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    // One idle edge, so a following write never re-raises the strobe in the same step
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask : rd
  task automatic pend(input logic [15:0] m);
    irqPending <= m;
    @(posedge clk);
    irqPending <= '0;
  endtask : pend
  // Urgency key: priority, then number, Secure bank first on a full tie
  function automatic int key(input int i);
    return int'(p[8*i+:8]) * 16 + (i % 8) * 2 + i / 8;
  endfunction : key
  // Waits for a handler start and checks entry results against the model
  task automatic serve(input int x, input bit fresh);
    int sx;
    int fw;
    sx = (coreSecure && x > 7) ? 10 : 0;
    fw = 8 + sx + (fpActive ? 18 + ((coreSecure && fpSecureTreatmentFlag) ? 16 : 0) : 0);
    n = 0;
    while (handlerStart !== 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    chk(32'(n < 500), 32'h1);
    chk(32'(linkRegWrite), 32'h1);
    chk(handlerPc, (x > 7 ? VN : VS) + 32'(4 * (16 + x % 8)) + 32'h1);
    chk(linkRegValue, {8'hff, 17'h1ffff, coreSecure, 1'b1, ~fpActive, 1'b1, spIsProcess, 2'h0});
    if (fresh)
    begin
      chk(32'(clearRegs), 32'(sx > 0));
      chk(core.words - w0, fw);
      chk(newSp, curSp - 32'(4 * fw));
      chk(core.mem[newSp + 32'(4 * (sx + 6))], returnAddr);
    end
    @(posedge clk);
  endtask : serve
  task automatic ret(input logic tc);
    pcWrite <= 1'b1;
    pcWriteKind <= 2'(1 + $urandom % 3);
    pcValue <= linkRegValue;
    @(posedge clk);
    pcWrite <= 1'b0;
    #1;
    chk(32'(tailChain), 32'(tc));
    chk(32'(unstackStart), 32'(!tc));
    @(posedge clk);
  endtask : ret
  task automatic results;
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // ====
  // Main sequence
  initial
  begin
    void'($urandom(32'hb5298057));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL);
    chk(d, 32'h0);
    rd(REG_STATUS);
    chk(d, 32'h1);
    rd(8'h3c);
    chk(d, 32'h0);
    // Pairs: plain, late arrival in one bank, full tie across banks
    for (it = 0; it < 12; it++)
    begin
      p = {$urandom, $urandom, $urandom, $urandom};
      a = $urandom % 16;
      b = (it % 3 == 2) ? (a ^ 8) : ((a & 8) | ((a + 1 + $urandom % 7) % 8));
      if (it % 3 == 2)
        p[8*b+:8] = p[8*a+:8];
      irqPrio <= p;
      {coreSecure, fpActive, fpSecureTreatmentFlag, spIsProcess} <= 4'($urandom);
      returnAddr <= $urandom;
      curSp <= {16'h2000, 13'($urandom), 3'h0};
      split = 3'($urandom);
      wr(REG_CTRL, {29'h0, split});
      gm = 8'hff << split;
      w = key(a) < key(b) ? a : b;
      l = a + b - w;
      f = (it % 3 == 1 && (p[8*w+:8] & gm) >= (p[8*l+:8] & gm)) ? l : w;
      s = a + b - f;
      w0 = core.words;
      if (it % 3 == 1)
      begin
        pend(16'(1 << l));
        n = 0;
        while (memWrite !== 1'b1 && n < 50)
        begin
          @(posedge clk);
          n++;
        end
        pend(16'(1 << w));
      end
      else
        pend(16'((1 << a) | (1 << b)));
      serve(f, 1'b1);
      rd(REG_PEND);
      chk(d, 32'(1 << s));
      rd(REG_ACTIVE);
      chk(d, 32'(1 << f));
      chk(32'(inHandlerMode), 32'h1);
      ret(1'b1);
      serve(s, 1'b0);
      ret(1'b0);
    end
    // Mask level at the boundary holds, one step above lets it in
    p = '0;
    p[40+:8] = 8'h40;
    irqPrio <= p;
    wr(REG_CTRL, 32'h0);
    wr(REG_MASK, 32'h140);
    w0 = core.words;
    pend(16'h0020);
    repeat (20) @(posedge clk);
    rd(REG_PEND);
    chk(d, 32'h20);
    chk(core.words - w0, 0);
    wr(REG_MASK, 32'h141);
    serve(5, 1'b1);
    ret(1'b0);
    results();
  end
endmodule : exception_entry_return_control_tb

// File: verilog/eer_arb_if.sv
interface eer_arb_if #(parameter int IW = 4);
  // Winner of one priority search
  logic             valid;
  logic [IW-1:0]    idx;
  logic [7:0]       group;
  logic [7:0]       sub;
  modport drive (output valid, output idx, output group, output sub);
  modport take  (input valid, input idx, input group, input sub);
endinterface : eer_arb_if

// File: verilog/eer_exception_ctrl.sv
// Notes on behaviour
// RULE_01: priority splits into group and subpriority
// RULE_02: preemption by group only; equal never preempts
// RULE_03: then subpriority, then lowest number first
// RULE_04: full tie: Secure bank wins
// RULE_05: pending qualifier at return skips unstacking
// RULE_06: later higher exception during stacking takes over
// RULE_07: enter when Thread mode or outranking handler
// RULE_08: masked exceptions stay pending, not taken
// RULE_09: fresh entry pushes frame on current stack
// RULE_10: Non-secure over Secure: extra context, clear; decided at fresh entry only, kept on late arrival and tail-chain
// RULE_11: extended FP frame if Secure and flag
// RULE_12: interrupted context stack pointer used for stacking
// RULE_13: stack pointer ends at lowest frame word
// RULE_14: vector fetch parallel; handler starts after both
// RULE_15: return token written into link register
// RULE_16: on start, pending becomes active
// RULE_17: late arrival leaves earlier pending untouched
// RULE_18: pop, load or branch-exchange to token returns
// RULE_19: token top byte is all ones
// RULE_20: bit6 stack security, bit5 default stacking
// RULE_21: bit4 clear when FP space allocated
// RULE_22: bit3 mode, bit2 stack, low bits zero
// RULE_23: lower value means more urgent
// RULE_24: software sets group/subpriority split point
//
// Chosen here: strobed register access and the placing of the registers.
module eer_exception_ctrl
  import eer_pkg::*;
#(
  parameter int          N_IRQ   = 8,
  parameter int          NSRC    = 2 * N_IRQ,
  parameter int          IW      = $clog2(NSRC),
  parameter bit          HAS_FP  = 1'b1,
  parameter logic [31:0] VBASE_S = 32'h00000000,
  parameter logic [31:0] VBASE_N = 32'h00000000
)(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [NSRC-1:0]        irqPending,
  input  wire logic [NSRC*PRIO_W-1:0] irqPrio,
  input  wire logic                   coreSecure,
  input  wire logic                   spIsProcess,
  input  wire logic [31:0]            curSp,
  input  wire logic                   fpActive,
  input  wire logic                   fpSecureTreatmentFlag,
  input  wire logic [31:0]            returnAddr,
  input  wire logic [31:0]            stackWordData,
  input  wire logic                   memReady,
  output      logic                   memWrite,
  output      logic [31:0]            memAddr,
  output      logic [31:0]            memWdata,
  output      logic [FW_W-1:0]        stackWordIdx,
  output      logic [31:0]            newSp,
  output      logic                   vecReq,
  output      logic [31:0]            vecAddr,
  input  wire logic                   vecValid,
  input  wire logic [31:0]            vecData,
  input  wire logic                   pcWrite,
  input  wire logic [1:0]             pcWriteKind,
  input  wire logic [31:0]            pcValue,
  output      logic                   handlerStart,
  output      logic [31:0]            handlerPc,
  output      logic                   linkRegWrite,
  output      logic [31:0]            linkRegValue,
  output      logic                   clearRegs,
  output      logic                   tailChain,
  output      logic                   unstackStart,
  output      logic                   inHandlerMode,
  input  wire logic [7:0]             regAddr,
  input  wire logic [31:0]            regWdata,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output      logic [31:0]            regRdata
);
  // ==========================================================
  // State
  eer_state_t        stateReg;
  eer_state_t        stateNext;
  logic [2:0]        splitReg;
  logic [PRIO_W-1:0] maskLevelReg;
  logic              maskEnReg;
  logic [NSRC-1:0]   pendReg;
  logic [NSRC-1:0]   activeReg;
  logic [IW-1:0]     entryIdxReg;
  logic [PRIO_W-1:0] entryGroupReg;
  logic [FW_W-1:0]   wordCntReg;
  logic [FW_W-1:0]   frameWordsReg;
  logic [FW_W-1:0]   retWordReg;
  logic [31:0]       addrReg;
  logic [31:0]       newSpReg;
  logic              vecDoneReg;
  logic [31:0]       handlerPcReg;
  logic [31:0]       tokenReg;
  logic              secExtraReg;
  logic [31:0]       regRdataReg;

  // ==========================================================
  // Two searches: pending winner and running handler
  eer_arb_if #(.IW(IW)) arbP ();
  eer_arb_if #(.IW(IW)) arbA ();

  eer_prio_arbiter #(.N_IRQ(N_IRQ), .NSRC(NSRC), .IW(IW)) u_pend_arb (
    .req   (pendReg),
    .prio  (irqPrio),
    .split (splitReg),
    .win   (arbP)
  );

  eer_prio_arbiter #(.N_IRQ(N_IRQ), .NSRC(NSRC), .IW(IW)) u_act_arb (
    .req   (activeReg),
    .prio  (irqPrio),
    .split (splitReg),
    .win   (arbA)
  );

  // ==========================================================
  // Qualification of the pending winner
  wire logic inHandler;
  wire logic maskOk;
  wire logic preemptOk;
  wire logic qualify;
  assign inHandler = |activeReg;
  assign maskOk    = !maskEnReg || (arbP.group < maskLevelReg); // RULE_08
  assign preemptOk = !inHandler || (arbP.group < arbA.group); // RULE_02 RULE_07
  assign qualify   = arbP.valid && maskOk && preemptOk; // RULE_07

  // Return request: handler mode, a loading kind, token prefix seen
  wire logic retNow;
  wire logic takeNow;
  wire logic lateArr;
  assign retNow  = (stateReg == S_RUN) && pcWrite && inHandler && (pcWriteKind != PCW_OTHER)
                   && (pcValue[31:24] == TOKEN_PREFIX); // RULE_18 RULE_19
  assign takeNow = (stateReg == S_RUN) && !retNow && qualify;
  // Only a strictly more urgent group steals an entry in progress
  assign lateArr = (stateReg == S_STACK) && arbP.valid && maskOk
                   && (arbP.group < entryGroupReg); // RULE_06

  // ==========================================================
  // Frame shape of a fresh entry
  wire logic            tgtNonSecure;
  wire logic            secExtra;
  wire logic            fpExtended;
  wire logic [FW_W-1:0] fpWords;
  wire logic [FW_W-1:0] secWords;
  wire logic [FW_W-1:0] frameWords;
  assign tgtNonSecure = (arbP.idx >= IW'(N_IRQ));
  assign secExtra     = coreSecure && tgtNonSecure; // RULE_10
  assign fpExtended   = coreSecure && fpSecureTreatmentFlag; // RULE_11
  assign fpWords      = (HAS_FP && fpActive) ? (fpExtended ? FRAME_FP_WORDS + FRAME_FPX_WORDS
                                                           : FRAME_FP_WORDS) : '0; // RULE_11
  assign secWords     = secExtra ? FRAME_SEC_WORDS : '0;
  assign frameWords   = FRAME_BASE_WORDS + secWords + fpWords;

  // Token built from the interrupted context
  wire logic [31:0] tokenNew;
  assign tokenNew = {TOKEN_PREFIX, TOKEN_FILL, // RULE_19
                     coreSecure, 1'b1, // RULE_20
                     HAS_FP ? !fpActive : 1'b1, // RULE_21
                     !inHandler, spIsProcess, TOKEN_LOW}; // RULE_22

  // ==========================================================
  // Stacking progress; the interrupted stack pointer is the base
  wire logic stackDone;
  wire logic stackStep;
  assign stackDone = (wordCntReg == frameWordsReg);
  assign stackStep = (stateReg == S_STACK) && !stackDone && memReady; // RULE_09

  // ==========================================================
  // Next state
  always_comb
  begin
    stateNext = stateReg;
    case (stateReg)
      S_RUN:
      begin
        if (retNow)
          stateNext = S_RET;
        else if (takeNow)
          stateNext = S_STACK;
      end
      S_STACK:
      begin
        if (stackDone && vecDoneReg && !lateArr) // RULE_14
          stateNext = S_START;
      end
      S_VECT:
      begin
        if (vecDoneReg)
          stateNext = S_START;
      end
      S_START: stateNext = S_RUN;
      S_RET:
      begin
        if (qualify)
          stateNext = S_VECT; // RULE_05
        else
          stateNext = S_RUN;
      end
      default: stateNext = S_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      stateReg <= S_RUN;
    else
      stateReg <= stateNext;
  end

  // ==========================================================
  // Pending and active sets; a new request wins over the clear
  wire logic [NSRC-1:0] pendClr;
  wire logic [NSRC-1:0] actSet;
  wire logic [NSRC-1:0] actClr;
  assign pendClr = (stateReg == S_START) ? (NSRC'(1) << entryIdxReg) : '0; // RULE_16
  assign actSet  = pendClr;
  assign actClr  = retNow ? (NSRC'(1) << arbA.idx) : '0;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pendReg   <= '0;
      activeReg <= '0;
    end
    else
    begin
      pendReg   <= (pendReg & ~pendClr) | irqPending; // RULE_17
      activeReg <= (activeReg | actSet) & ~actClr; // RULE_16
    end
  end

  // ==========================================================
  // Entry target; switched on late arrival or tail-chain
  wire logic newTarget;
  assign newTarget = takeNow || lateArr || ((stateReg == S_RET) && qualify);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      entryIdxReg   <= '0;
      entryGroupReg <= '0;
    end
    else if (newTarget)
    begin
      entryIdxReg   <= arbP.idx; // RULE_06
      entryGroupReg <= arbP.group;
    end
  end

  // Frame capture at a fresh entry only; tail-chain keeps the old frame
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      frameWordsReg <= '0;
      retWordReg    <= '0;
      newSpReg      <= '0;
      tokenReg      <= '0;
      secExtraReg   <= 1'b0;
    end
    else if (takeNow)
    begin
      frameWordsReg <= frameWords;
      retWordReg    <= secWords + RET_ADDR_WORD; // RULE_13
      newSpReg      <= curSp - {24'h0, frameWords, 2'b00}; // RULE_12 RULE_13
      tokenReg      <= tokenNew; // RULE_15
      secExtraReg   <= secExtra;
    end
  end

  // Stack word walk upward from the lowest address
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wordCntReg <= '0;
      addrReg    <= '0;
    end
    else if (takeNow)
    begin
      wordCntReg <= '0;
      addrReg    <= curSp - {24'h0, frameWords, 2'b00}; // RULE_12
    end
    else if (stackStep)
    begin
      wordCntReg <= wordCntReg + 6'h01;
      addrReg    <= addrReg + 32'h4;
    end
  end

  // ==========================================================
  // Vector fetch; a late arrival restarts it for the new target
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      vecDoneReg   <= 1'b0;
      handlerPcReg <= '0;
    end
    else if (newTarget)
      vecDoneReg <= 1'b0; // RULE_06
    else if (vecReq && vecValid)
    begin
      vecDoneReg   <= 1'b1; // RULE_14
      handlerPcReg <= vecData;
    end
  end

  wire logic [31:0] vecNum;
  wire logic        entryNonSec;
  assign entryNonSec = (entryIdxReg >= IW'(N_IRQ));
  assign vecNum      = 32'(entryIdxReg) - (entryNonSec ? 32'(N_IRQ) : 32'h0) + 32'(VEC_FIRST_IRQ);
  assign vecAddr     = (entryNonSec ? VBASE_N : VBASE_S) + {vecNum[29:0], 2'b00};
  assign vecReq      = ((stateReg == S_STACK) || (stateReg == S_VECT)) && !vecDoneReg; // RULE_14

  // ==========================================================
  // Stack memory port; return address sits at its frame slot
  assign memWrite     = (stateReg == S_STACK) && !stackDone; // RULE_09
  assign memAddr      = addrReg;
  assign stackWordIdx = wordCntReg;
  assign memWdata     = (wordCntReg == retWordReg) ? returnAddr : stackWordData; // RULE_13
  assign newSp        = newSpReg;

  // ==========================================================
  // Core side pulses
  assign handlerStart  = (stateReg == S_START); // RULE_16
  assign linkRegWrite  = (stateReg == S_START); // RULE_15
  assign clearRegs     = (stateReg == S_START) && secExtraReg; // RULE_10
  assign tailChain     = (stateReg == S_RET) && qualify; // RULE_05
  assign unstackStart  = (stateReg == S_RET) && !qualify;
  assign handlerPc     = handlerPcReg;
  assign linkRegValue  = tokenReg;
  assign inHandlerMode = inHandler;

  // ==========================================================
  // Register bus; unmapped reads return zero
  wire logic wrCtrl;
  wire logic wrMask;
  assign wrCtrl = regWrite && (regAddr == REG_CTRL);
  assign wrMask = regWrite && (regAddr == REG_MASK);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      splitReg <= CTRL_SPLIT_RESET;
    else if (wrCtrl)
      splitReg <= regWdata[CTRL_SPLIT_LSB +: CTRL_SPLIT_W]; // RULE_24
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      maskLevelReg <= MASK_LEVEL_RESET;
      maskEnReg    <= MASK_EN_RESET;
    end
    else if (wrMask)
    begin
      maskLevelReg <= regWdata[MASK_LEVEL_LSB +: PRIO_W];
      maskEnReg    <= regWdata[MASK_EN_BIT];
    end
  end

  // Read mux; sets wider than 32 sources show only the low word
  wire logic [31:0] statusWord;
  wire logic [31:0] pendWord;
  wire logic [31:0] activeWord;
  wire logic [31:0] readMux;
  assign statusWord = 32'(stateReg) | (32'(inHandler) << STAT_HANDLER_BIT)
                      | (32'(arbA.idx) << STAT_RUNIDX_LSB);
  assign pendWord   = 32'(pendReg);
  assign activeWord = 32'(activeReg);
  assign readMux    = (regAddr == REG_CTRL)   ? 32'(splitReg) :
                      (regAddr == REG_MASK)   ? ((32'(maskEnReg) << MASK_EN_BIT) | 32'(maskLevelReg)) :
                      (regAddr == REG_STATUS) ? statusWord :
                      (regAddr == REG_PEND)   ? pendWord :
                      (regAddr == REG_ACTIVE) ? activeWord : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      regRdataReg <= '0;
    else if (regRead)
      regRdataReg <= readMux;
  end
  assign regRdata = regRdataReg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_taken;
    takeNow;
  endsequence
  sequence seq_ret_pending;
    (stateReg == S_RET) && qualify;
  endsequence

  a_enter_stack: assert property (seq_taken |=> (stateReg == S_STACK) && (wordCntReg == 6'h00)) // RULE_07
    else $error("qualified exception not entered");
  a_mask_hold: assert property ((stateReg == S_RUN) && !maskOk |=> (stateReg != S_STACK)) // RULE_08
    else $error("masked exception was taken");
  a_same_group: assert property ((stateReg == S_RUN) && inHandler && (arbP.group >= arbA.group)
                                 |=> (stateReg != S_STACK)) // RULE_02
    else $error("equal group preempted handler");
  a_token_form: assert property (linkRegWrite |-> (linkRegValue[31:24] == 8'hff)
                                 && (linkRegValue[1:0] == 2'h0)) // RULE_19
    else $error("bad return token form");
  a_pend_active: assert property (handlerStart |=> activeReg[$past(entryIdxReg)]) // RULE_16
    else $error("entry not marked active");
  a_sp_lowest: assert property (seq_taken |=> (memAddr == newSp) ##1 (memAddr >= newSp)) // RULE_13
    else $error("frame not built from lowest address");
  a_tail_skip: assert property (seq_ret_pending |-> !unstackStart ##1 (stateReg == S_VECT)) // RULE_05
    else $error("tail-chain did not skip unstacking");
  a_late_switch: assert property (lateArr |=> (entryIdxReg == $past(arbP.idx)) && !vecDoneReg) // RULE_06
    else $error("late arrival not switched");
  a_late_keep: assert property (lateArr |=> pendReg[$past(entryIdxReg)]) // RULE_17
    else $error("earlier pending lost on late arrival");
  a_ret_decode: assert property (retNow |=> (stateReg == S_RET) && (tailChain || unstackStart)) // RULE_18
    else $error("return token not handled");
endmodule : eer_exception_ctrl

// File: verilog/eer_pkg.sv
package eer_pkg;
  // ==========================================================
  // Widths
  localparam int PRIO_W = 8;
  localparam int FW_W   = 6;

  // ==========================================================
  // Register offsets and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PEND   = 8'h0c;
  localparam logic [7:0] REG_ACTIVE = 8'h10;
  localparam int CTRL_SPLIT_LSB   = 0;
  localparam int CTRL_SPLIT_W     = 3;
  localparam int MASK_LEVEL_LSB   = 0;
  localparam int MASK_EN_BIT      = 8;
  localparam int STAT_HANDLER_BIT = 5;
  localparam int STAT_RUNIDX_LSB  = 8;
  localparam logic [2:0]        CTRL_SPLIT_RESET = 3'h0;
  localparam logic [PRIO_W-1:0] MASK_LEVEL_RESET = 8'h00;
  localparam logic              MASK_EN_RESET    = 1'b0;

  // ==========================================================
  // Exception return token layout
  localparam logic [7:0]  TOKEN_PREFIX = 8'hff;
  localparam logic [16:0] TOKEN_FILL   = 17'h1ffff;
  localparam logic [1:0]  TOKEN_LOW    = 2'h0;

  // ==========================================================
  // Stack frame sizes and return address slot in words, first IRQ vector number
  localparam logic [FW_W-1:0] FRAME_BASE_WORDS = 6'h08;
  localparam logic [FW_W-1:0] FRAME_SEC_WORDS  = 6'h0a;
  localparam logic [FW_W-1:0] FRAME_FP_WORDS   = 6'h12;
  localparam logic [FW_W-1:0] FRAME_FPX_WORDS  = 6'h10;
  localparam logic [FW_W-1:0] RET_ADDR_WORD    = 6'h06;
  localparam int VEC_FIRST_IRQ = 16;

  // ==========================================================
  // Sequencer states and program counter write kinds
  typedef enum logic [4:0] {
    S_RUN   = 5'b00001,
    S_STACK = 5'b00010,
    S_VECT  = 5'b00100,
    S_START = 5'b01000,
    S_RET   = 5'b10000
  } eer_state_t;
  localparam logic [1:0] PCW_OTHER = 2'h0;
endpackage : eer_pkg

// File: verilog/eer_prio_arbiter.sv
module eer_prio_arbiter
  import eer_pkg::*;
#(
  parameter int N_IRQ = 8,
  parameter int NSRC  = 2 * N_IRQ,
  parameter int IW    = $clog2(NSRC)
)(
  input  wire logic [NSRC-1:0]        req,
  input  wire logic [NSRC*PRIO_W-1:0] prio,
  input  wire logic [2:0]             split,
  eer_arb_if.drive                    win
);
  localparam int KW = 2 * PRIO_W + IW + 1;

  // ==========================================================
  // Field split shared by every entry
  wire logic [PRIO_W-1:0] groupMask;
  assign groupMask = 8'hff << split; // RULE_24

  logic [KW-1:0] bestKey [0:NSRC];
  logic          bestVal [0:NSRC];
  logic [IW-1:0] bestIdx [0:NSRC];

  assign bestKey[0] = '0;
  assign bestVal[0] = 1'b0;
  assign bestIdx[0] = '0;

  // ==========================================================
  // Linear scan; key order is group, sub, number, then secure first
  for (genvar i = 0; i < NSRC; i++)
  begin : g_scan
    wire logic [PRIO_W-1:0] p;
    wire logic [KW-1:0]     key;
    wire logic              better;
    assign p   = prio[i*PRIO_W +: PRIO_W];
    assign key = {p & groupMask, p & ~groupMask, // RULE_01 RULE_03 RULE_23
                  IW'(i % N_IRQ), (i >= N_IRQ) ? 1'b1 : 1'b0}; // RULE_04
    assign better = req[i] && (!bestVal[i] || key < bestKey[i]);
    assign bestKey[i+1] = better ? key : bestKey[i];
    assign bestVal[i+1] = better | bestVal[i];
    assign bestIdx[i+1] = better ? IW'(i) : bestIdx[i];
  end

  assign win.valid = bestVal[NSRC];
  assign win.idx   = bestIdx[NSRC];
  assign win.group = bestKey[NSRC][KW-1 -: PRIO_W];
  assign win.sub   = bestKey[NSRC][KW-1-PRIO_W -: PRIO_W];
endmodule : eer_prio_arbiter
